// File: hw/cmpvr_top.sv
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
// How it works
// - Without inversion the result is high when plus input exceeds minus input.
// - The output_invert bit complements the raw comparison; clearing it restores it.
// - Three comparator_mode_sel bits choose one of eight operating modes.
// - Pin direction bit 2 governs only output_pin_2, and only in the three output modes.
// - compare_result is read from comparator_control and ignores writes.
// - Three modes drive the unsynchronised result straight onto output_pin_2.
// - In output modes pin_direction bit 2 low lets output_pin_2 drive.
// - Reading port_pins returns zero for every pin set as analog input.
// - Four modes feed the internal reference, not a pin, to one input.
// - Thirty-two levels: sixteen low range when range is one, sixteen high.
// - Low tap is level/24 of supply; high tap is 1/4 plus level/32.
// - Mode 111 turns the comparator off; reference_power low powers reference down.
// - An enabled comparator and reference keep running through Sleep.
// - A comparator change event during Sleep with comparator enabled wakes device.
// - Waking leaves comparator_control and reference_control untouched.
// - Reset loads both control registers: mode 000 and reference off.
// - After reset all comparator pins are analog with everything disabled.
// - Unimplemented reference_control bits read zero; implemented bits reset zero, read/write.
// - In modes 110 and 101 input_switch picks the pin for the minus input.
// - A result change sets compare_change_flag; software clears it by writing zero.
// - Any access to comparator_control ends the mismatch so the flag stays clear.
module cmpvr_top #(
  parameter int PIN_COUNT = 6,
  parameter cmpvr_pkg::cmpvr_mode_type [7:0] MODE_TABLE = cmpvr_pkg::MODE_TABLE_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire cmpvr_pkg::cmpvr_av_req_type av_req,
  output logic av_waitrequest,
  output logic [cmpvr_pkg::AV_DATA_W-1:0] av_readdata,
  input wire logic [cmpvr_pkg::LVL_W-1:0] pos_pin_level,
  input wire logic [cmpvr_pkg::LVL_W-1:0] neg_pin_level,
  input wire logic [PIN_COUNT-1:0] pin_direction,
  input wire logic [PIN_COUNT-1:0] port_pins_in,
  input wire logic sleep_mode,
  output logic [cmpvr_pkg::LVL_W-1:0] ref_level_out,
  output logic ref_enabled,
  output logic comparator_enabled,
  output logic [PIN_COUNT-1:0] analog_pins,
  output logic cmp_pin2_out,
  output logic cmp_pin2_oe_n,
  output logic compare_change_flag,
  output logic wake_request
);

  if (PIN_COUNT < 3 || PIN_COUNT > 8) begin : g_pin_check
    $error("cmpvr_top needs PIN_COUNT from three to eight");
  end

  cmpvr_pkg::cmpvr_state_type st_reg;
  cmpvr_pkg::cmpvr_state_type st_next;

  cmpvr_pkg::cmpvr_mode_type mode_entry;
  logic [cmpvr_pkg::LVL_W-1:0] plus_level;
  logic [cmpvr_pkg::LVL_W-1:0] minus_level;
  logic raw_greater;
  logic cmp_result;
  logic [PIN_COUNT:0] sync_in;
  logic [PIN_COUNT:0] sync_out;
  logic result_sync;
  logic [PIN_COUNT-1:0] pins_sync;
  logic [PIN_COUNT-1:0] analog_mask_full;
  logic mismatch;
  logic bus_req;
  logic bus_accept;
  logic [7:0] bus_index;
  logic write_lane0;

  // Ladder tap as a fraction of supply in steps of supply/96.
  function automatic logic [cmpvr_pkg::LVL_W-1:0] ladder_tap(
    input logic low_range,
    input logic [3:0] level
  );
    logic [cmpvr_pkg::LVL_W-1:0] lvl;
    lvl = {3'h0, level};
    if (low_range) begin
      ladder_tap = 7'(lvl * cmpvr_pkg::LOW_STEP);
    end else begin
      ladder_tap = 7'(cmpvr_pkg::HIGH_BASE + 7'(lvl * cmpvr_pkg::HIGH_STEP));
    end
  endfunction

  // Source of one comparator input as selected by the decode table.
  function automatic logic [cmpvr_pkg::LVL_W-1:0] pick_source(
    input cmpvr_pkg::cmpvr_src_type src,
    input logic in_switch,
    input logic [cmpvr_pkg::LVL_W-1:0] pos_lvl,
    input logic [cmpvr_pkg::LVL_W-1:0] neg_lvl,
    input logic [cmpvr_pkg::LVL_W-1:0] ref_lvl
  );
    case (src)
      cmpvr_pkg::SRC_POS_PIN: pick_source = pos_lvl;
      cmpvr_pkg::SRC_NEG_PIN: pick_source = neg_lvl;
      cmpvr_pkg::SRC_REF: pick_source = ref_lvl;
      cmpvr_pkg::SRC_SWITCH: pick_source = in_switch ? pos_lvl : neg_lvl;
      default: pick_source = neg_lvl;
    endcase
  endfunction

  function automatic logic is_index(
    input logic [7:0] index,
    input logic [7:0] target
  );
    is_index = (index == target);
  endfunction

  // Mode decode. The table is a parameter so the routing can be changed without touching the logic.
  assign mode_entry = MODE_TABLE[st_reg.cctrl.mode];

  assign plus_level = pick_source(mode_entry.plus_src, st_reg.cctrl.in_switch,
                                  pos_pin_level, neg_pin_level, st_reg.ref_level);
  assign minus_level = pick_source(mode_entry.minus_src, st_reg.cctrl.in_switch,
                                   pos_pin_level, neg_pin_level, st_reg.ref_level);

  // The comparison itself is combinational, standing in for the analog stage.
  // Equal levels count as not greater.
  assign raw_greater = plus_level > minus_level;
  assign cmp_result = mode_entry.comp_on & (raw_greater ^ st_reg.cctrl.invert);

  // The pin path is deliberately not retimed, so it follows the comparator
  // with no clock latency and may glitch while the inputs cross.
  assign cmp_pin2_out = cmp_result;
  assign cmp_pin2_oe_n = ~(mode_entry.out_en & ~pin_direction[2]);

  // The result and the port pins come from outside the clock domain.
  assign sync_in = {cmp_result, port_pins_in};

  cmpvr_sync #(
    .WIDTH(PIN_COUNT + 1)
  ) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in(sync_in),
    .stable(sync_out)
  );

  assign result_sync = sync_out[PIN_COUNT];
  assign pins_sync = sync_out[PIN_COUNT-1:0];
  assign analog_mask_full = {{(PIN_COUNT-3){1'b0}}, mode_entry.analog_mask};

  // Mismatch holds until an access to comparator_control copies the current result.
  assign mismatch = result_sync != st_reg.snap;

  // Bus slave: one wait cycle on every access, answer on the second edge.
  assign bus_req = av_req.read | av_req.write;
  assign bus_accept = bus_req & st_reg.ack;
  assign bus_index = av_req.address[9:2];
  assign write_lane0 = av_req.write & av_req.byteenable[0];
  assign av_waitrequest = bus_req & ~st_reg.ack;

  always_comb begin
    st_next = st_reg;
    st_next.ack = bus_req & ~st_reg.ack;

    // Read data are captured in the wait cycle so they stand at the answering edge.
    if (av_req.read && !st_reg.ack) begin
      st_next.rdata = cmpvr_pkg::RDATA_RESET;
      if (is_index(bus_index, cmpvr_pkg::IDX_COMP_CTRL)) begin
        st_next.rdata[cmpvr_pkg::CC_RESULT_BIT] = result_sync;
        st_next.rdata[cmpvr_pkg::CC_INVERT_BIT] = st_reg.cctrl.invert;
        st_next.rdata[cmpvr_pkg::CC_SWITCH_BIT] = st_reg.cctrl.in_switch;
        st_next.rdata[cmpvr_pkg::CC_MODE_LSB +: 3] = st_reg.cctrl.mode;
      end else if (is_index(bus_index, cmpvr_pkg::IDX_REF_CTRL)) begin
        st_next.rdata[cmpvr_pkg::RC_POWER_BIT] = st_reg.rctrl.power;
        st_next.rdata[cmpvr_pkg::RC_RANGE_BIT] = st_reg.rctrl.range;
        st_next.rdata[cmpvr_pkg::RC_LEVEL_LSB +: 4] = st_reg.rctrl.level;
      end else if (is_index(bus_index, cmpvr_pkg::IDX_CHANGE_FLAG)) begin
        st_next.rdata[cmpvr_pkg::FLAG_BIT] = st_reg.change_flag;
      end else if (is_index(bus_index, cmpvr_pkg::IDX_PORT_PINS)) begin
        st_next.rdata[PIN_COUNT-1:0] = pins_sync & ~analog_mask_full;
      end
    end

    if (bus_accept && write_lane0) begin
      if (is_index(bus_index, cmpvr_pkg::IDX_COMP_CTRL)) begin
        // The result bit is not writable; only the control fields change.
        st_next.cctrl.invert = av_req.writedata[cmpvr_pkg::CC_INVERT_BIT];
        st_next.cctrl.in_switch = av_req.writedata[cmpvr_pkg::CC_SWITCH_BIT];
        st_next.cctrl.mode = av_req.writedata[cmpvr_pkg::CC_MODE_LSB +: 3];
      end else if (is_index(bus_index, cmpvr_pkg::IDX_REF_CTRL)) begin
        st_next.rctrl.power = av_req.writedata[cmpvr_pkg::RC_POWER_BIT];
        st_next.rctrl.range = av_req.writedata[cmpvr_pkg::RC_RANGE_BIT];
        st_next.rctrl.level = av_req.writedata[cmpvr_pkg::RC_LEVEL_LSB +: 4];
      end else if (is_index(bus_index, cmpvr_pkg::IDX_CHANGE_FLAG)) begin
        // Writing one raises the flag as a software-made event.
        st_next.change_flag = av_req.writedata[cmpvr_pkg::FLAG_BIT];
      end
    end

    // Any accepted read or write of comparator_control ends the mismatch.
    if (bus_accept && is_index(bus_index, cmpvr_pkg::IDX_COMP_CTRL)) begin
      st_next.snap = result_sync;
    end

    // A change seen in the same cycle as a clearing write keeps the flag set.
    if (mismatch) begin
      st_next.change_flag = 1'b1;
    end

    // Only the wake request depends on sleep_mode, so an enabled comparator and
    // reference keep running and the control registers survive a wake.
    st_next.ref_level = st_reg.rctrl.power ? ladder_tap(st_reg.rctrl.range, st_reg.rctrl.level)
                                           : cmpvr_pkg::LEVEL_OFF;
    st_next.wake = sleep_mode & mode_entry.comp_on & mismatch;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg.cctrl.invert <= 1'b0;
      st_reg.cctrl.in_switch <= 1'b0;
      st_reg.cctrl.mode <= cmpvr_pkg::MODE_RESET;
      st_reg.rctrl.power <= 1'b0;
      st_reg.rctrl.range <= 1'b0;
      st_reg.rctrl.level <= cmpvr_pkg::LEVEL_RESET;
      st_reg.change_flag <= 1'b0;
      st_reg.snap <= 1'b0;
      st_reg.ack <= 1'b0;
      st_reg.rdata <= cmpvr_pkg::RDATA_RESET;
      st_reg.ref_level <= cmpvr_pkg::LEVEL_OFF;
      st_reg.wake <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign av_readdata = st_reg.rdata;
  assign ref_level_out = st_reg.ref_level;
  assign ref_enabled = st_reg.rctrl.power;
  assign comparator_enabled = mode_entry.comp_on;
  assign analog_pins = analog_mask_full;
  assign compare_change_flag = st_reg.change_flag;
  assign wake_request = st_reg.wake;

endmodule

// File: common/cmpvr_pkg.sv
package cmpvr_pkg;

  // Ladder levels are carried as fractions of the supply in steps of supply/96,
  // the smallest step that holds both the /24 and the /32 taps exactly.
  localparam int LVL_W = 7;
  localparam logic [6:0] LADDER_FULL = 7'h60;
  localparam logic [6:0] HIGH_BASE = 7'h18;
  localparam logic [6:0] LOW_STEP = 7'h04;
  localparam logic [6:0] HIGH_STEP = 7'h03;
  localparam logic [6:0] LEVEL_OFF = 7'h00;

  localparam int AV_ADDR_W = 10;
  localparam int AV_DATA_W = 32;
  localparam logic [7:0] IDX_PORT_PINS = 8'h05;
  localparam logic [7:0] IDX_CHANGE_FLAG = 8'h0C;
  localparam logic [7:0] IDX_COMP_CTRL = 8'h19;
  localparam logic [7:0] IDX_REF_CTRL = 8'h99;

  localparam int CC_MODE_LSB = 0;
  localparam int CC_SWITCH_BIT = 3;
  localparam int CC_INVERT_BIT = 4;
  localparam int CC_RESULT_BIT = 6;
  localparam int RC_LEVEL_LSB = 0;
  localparam int RC_RANGE_BIT = 5;
  localparam int RC_POWER_BIT = 7;
  localparam int FLAG_BIT = 3;

  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [3:0] LEVEL_RESET = 4'h0;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    SRC_POS_PIN = 2'b00,
    SRC_NEG_PIN = 2'b01,
    SRC_REF = 2'b10,
    SRC_SWITCH = 2'b11
  } cmpvr_src_type;

  typedef struct packed {
    logic comp_on;
    logic out_en;
    logic [2:0] analog_mask;
    cmpvr_src_type plus_src;
    cmpvr_src_type minus_src;
  } cmpvr_mode_type;

  localparam cmpvr_mode_type [7:0] MODE_TABLE_DEFAULT = '{
    '{1'h0, 1'h0, 3'h0, SRC_POS_PIN, SRC_NEG_PIN},
    '{1'h1, 1'h1, 3'h3, SRC_REF, SRC_SWITCH},
    '{1'h1, 1'h0, 3'h3, SRC_REF, SRC_SWITCH},
    '{1'h1, 1'h0, 3'h2, SRC_REF, SRC_NEG_PIN},
    '{1'h1, 1'h1, 3'h2, SRC_REF, SRC_NEG_PIN},
    '{1'h1, 1'h0, 3'h3, SRC_POS_PIN, SRC_NEG_PIN},
    '{1'h1, 1'h1, 3'h3, SRC_POS_PIN, SRC_NEG_PIN},
    '{1'h0, 1'h0, 3'h7, SRC_POS_PIN, SRC_NEG_PIN}
  };

  typedef struct packed {
    logic invert;
    logic in_switch;
    logic [2:0] mode;
  } cmpvr_cctrl_type;

  typedef struct packed {
    logic power;
    logic range;
    logic [3:0] level;
  } cmpvr_rctrl_type;

  typedef struct packed {
    logic read;
    logic write;
    logic [AV_ADDR_W-1:0] address;
    logic [AV_DATA_W-1:0] writedata;
    logic [3:0] byteenable;
  } cmpvr_av_req_type;

  typedef struct packed {
    cmpvr_cctrl_type cctrl;
    cmpvr_rctrl_type rctrl;
    logic change_flag;
    logic snap;
    logic ack;
    logic [AV_DATA_W-1:0] rdata;
    logic [LVL_W-1:0] ref_level;
    logic wake;
  } cmpvr_state_type;

endpackage

// File: hw/cmpvr_sync.sv
`timescale 1ns/1ps
module cmpvr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] stable
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] hold;
  } cmpvr_sync_state_type;

  cmpvr_sync_state_type st_reg;
  cmpvr_sync_state_type st_next;

  if (WIDTH < 1) begin : g_width_check
    $error("cmpvr_sync needs WIDTH of at least one");
  end

  // Only bits on which the second and third stages agree are taken, so a
  // level that is still settling never reaches the register file.
  always_comb begin
    st_next = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.hold = (st_reg.hold & (st_reg.s2 ^ st_reg.s3)) | (st_reg.s3 & ~(st_reg.s2 ^ st_reg.s3));
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign stable = st_reg.hold;

endmodule

// File: sim/cmpvr_analog_model.sv
`timescale 1ns/1ps
module cmpvr_analog_model (
  input wire logic [6:0] pos_set,
  input wire logic [6:0] neg_set,
  input wire logic [5:0] dig_set,
  output logic [6:0] pos_pin_level,
  output logic [6:0] neg_pin_level,
  output logic [5:0] port_pins_in
);
  // An outside source cannot swing past the supply rail, so the levels clip at full scale.
  assign pos_pin_level = (pos_set > cmpvr_pkg::LADDER_FULL) ? cmpvr_pkg::LADDER_FULL : pos_set;
  assign neg_pin_level = (neg_set > cmpvr_pkg::LADDER_FULL) ? cmpvr_pkg::LADDER_FULL : neg_set;
  assign port_pins_in = dig_set;
endmodule

// File: sim/cmpvr_assertions.sv
`timescale 1ns/1ps
module cmpvr_assertions #(
  parameter int PIN_COUNT = 6
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire cmpvr_pkg::cmpvr_av_req_type av_req,
  input wire logic av_waitrequest,
  input wire logic [31:0] av_readdata,
  input wire logic [6:0] pos_pin_level,
  input wire logic [6:0] neg_pin_level,
  input wire logic [PIN_COUNT-1:0] pin_direction,
  input wire logic [PIN_COUNT-1:0] port_pins_in,
  input wire logic sleep_mode,
  input wire logic [6:0] ref_level_out,
  input wire logic ref_enabled,
  input wire logic comparator_enabled,
  input wire logic [PIN_COUNT-1:0] analog_pins,
  input wire logic cmp_pin2_out,
  input wire logic cmp_pin2_oe_n,
  input wire logic compare_change_flag,
  input wire logic wake_request
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_oe_mode: assert property (!cmp_pin2_oe_n |-> comparator_enabled && !analog_pins[2] && !pin_direction[2])
    else $error("pin 2 driven outside an output mode");
  a_dir_gate: assert property (pin_direction[2] |-> cmp_pin2_oe_n)
    else $error("pin 2 driven while its direction is input");
  a_off_quiet: assert property (!comparator_enabled |-> !cmp_pin2_out && cmp_pin2_oe_n)
    else $error("comparator off but pin 2 active");
  a_ref_off: assert property (!ref_enabled && !$past(ref_enabled) |-> ref_level_out == cmpvr_pkg::LEVEL_OFF)
    else $error("reference off but tap not zero");
  a_ref_span: assert property (ref_level_out <= 7'h45)
    else $error("reference tap above highest ladder level");
  a_upper_digital: assert property (analog_pins[PIN_COUNT-1:3] == '0)
    else $error("non comparator pin marked analog");
  a_wake_cause: assert property ($rose(wake_request) |-> $past(sleep_mode) && $past(comparator_enabled))
    else $error("wake without sleep and comparator on");
  a_wake_flag: assert property (wake_request |-> compare_change_flag)
    else $error("wake without change flag");
  a_flag_hold: assert property (compare_change_flag && !av_req.write |=> compare_change_flag)
    else $error("change flag cleared without a write");
  a_sleep_keep: assert property (sleep_mode && !av_req.write |=> $stable(ref_enabled) && $stable(comparator_enabled))
    else $error("control state changed in sleep without a write");
endmodule
bind cmpvr_top cmpvr_assertions #(.PIN_COUNT(PIN_COUNT)) u_chk (.ref_clk(ref_clk), .resetn(resetn),
  .av_req(av_req), .av_waitrequest(av_waitrequest), .av_readdata(av_readdata), .pos_pin_level(pos_pin_level),
  .neg_pin_level(neg_pin_level), .pin_direction(pin_direction), .port_pins_in(port_pins_in), .sleep_mode(sleep_mode),
  .ref_level_out(ref_level_out), .ref_enabled(ref_enabled), .comparator_enabled(comparator_enabled),
  .analog_pins(analog_pins), .cmp_pin2_out(cmp_pin2_out), .cmp_pin2_oe_n(cmp_pin2_oe_n),
  .compare_change_flag(compare_change_flag), .wake_request(wake_request));

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  cmpvr_pkg::cmpvr_av_req_type av_req = '0;
  logic av_waitrequest, ref_enabled, comparator_enabled, cmp_pin2_out, cmp_pin2_oe_n;
  logic compare_change_flag, wake_request, sleep_mode = 1'b0;
  logic [31:0] av_readdata;
  logic [6:0] ref_level_out, pos_pin_level, neg_pin_level, pos_set = 7'h00, neg_set = 7'h00;
  logic [5:0] pin_direction = 6'h3F, analog_pins, port_pins_in, dig_set = 6'h00;
  logic [7:0] rdv;
  int failures = 0;
  int tests_run = 0;
  always #50 ref_clk = ~ref_clk;
  cmpvr_analog_model u_src (.pos_set(pos_set), .neg_set(neg_set), .dig_set(dig_set),
    .pos_pin_level(pos_pin_level), .neg_pin_level(neg_pin_level), .port_pins_in(port_pins_in));
  cmpvr_top dut (.ref_clk(ref_clk), .resetn(resetn), .av_req(av_req), .av_waitrequest(av_waitrequest),
    .av_readdata(av_readdata), .pos_pin_level(pos_pin_level), .neg_pin_level(neg_pin_level),
    .pin_direction(pin_direction), .port_pins_in(port_pins_in), .sleep_mode(sleep_mode),
    .ref_level_out(ref_level_out), .ref_enabled(ref_enabled), .comparator_enabled(comparator_enabled),
    .analog_pins(analog_pins), .cmp_pin2_out(cmp_pin2_out), .cmp_pin2_oe_n(cmp_pin2_oe_n),
    .compare_change_flag(compare_change_flag), .wake_request(wake_request));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask
  // Waitrequest is sampled at the rising edge, before the slave's registers move,
  // and the request stands until that edge sees it low.
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge ref_clk);
    av_req <= '{!wr, wr, {idx, 2'b00}, {24'h000000, wd}, 4'hF};
    @(posedge ref_clk);
    while (av_waitrequest !== 1'b0) begin
      @(posedge ref_clk);
    end
    rdv = av_readdata[7:0];
    av_req <= '0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input string n);
    bus(1'b0, idx, 8'h00);
    chk(n, e, rdv);
  endtask
  // Four synchroniser edges plus the flag edge, with one to spare.
  task automatic settle;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic t_reset;
    chk("analog_pins", 8'h07, {2'b00, analog_pins});
    chk_bit("comparator_enabled", 1'b0, comparator_enabled);
    chk_bit("ref_enabled", 1'b0, ref_enabled);
    rd(8'h19, 8'h00, "comparator_control");
    rd(8'h99, 8'h00, "reference_control");
  endtask
  task automatic t_ref;
    int e;
    for (int l = 0; l < 32; l++) begin
      bus(1'b1, 8'h99, {2'b10, l[4], 1'b0, l[3:0]});
      repeat (2) @(negedge ref_clk);
      e = l[4] ? (l % 16) * 4 : 24 + (l % 16) * 3;
      chk("ref_level_out", e[7:0], {1'b0, ref_level_out});
      rd(8'h99, {2'b10, l[4], 1'b0, l[3:0]}, "reference_control");
    end
    bus(1'b1, 8'h99, 8'hFF);
    rd(8'h99, 8'hAF, "reference_control");
    bus(1'b1, 8'h99, 8'h2F);
    repeat (2) @(negedge ref_clk);
    chk("ref_level_out", 8'h00, {1'b0, ref_level_out});
    chk_bit("ref_enabled", 1'b0, ref_enabled);
  endtask
  task automatic t_modes;
    logic [2:0] am [8] = '{3'h7, 3'h3, 3'h3, 3'h2, 3'h2, 3'h3, 3'h3, 3'h0};
    @(posedge ref_clk);
    pin_direction <= 6'h3B;
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, 8'h19, m[7:0]);
      @(negedge ref_clk);
      chk("analog_pins", {5'h00, am[m]}, {2'b00, analog_pins});
      chk_bit("comparator_enabled", m != 0 && m != 7, comparator_enabled);
      chk_bit("cmp_pin2_oe_n", !(m == 1 || m == 3 || m == 6), cmp_pin2_oe_n);
    end
    bus(1'b1, 8'h19, 8'h06);
    @(posedge ref_clk);
    pin_direction <= 6'h3F;
    @(negedge ref_clk);
    chk_bit("cmp_pin2_oe_n", 1'b1, cmp_pin2_oe_n);
  endtask
  task automatic t_cmp;
    @(posedge ref_clk);
    pos_set <= 7'h3C;
    neg_set <= 7'h1E;
    pin_direction <= 6'h3B;
    bus(1'b1, 8'h19, 8'h01);
    settle;
    chk_bit("cmp_pin2_out", 1'b1, cmp_pin2_out);
    rd(8'h19, 8'h41, "comparator_control");
    bus(1'b1, 8'h19, 8'h11);
    settle;
    chk_bit("cmp_pin2_out", 1'b0, cmp_pin2_out);
    rd(8'h19, 8'h11, "comparator_control");
    @(posedge ref_clk);
    pos_set <= 7'h1E;
    neg_set <= 7'h3C;
    bus(1'b1, 8'h19, 8'h41);
    settle;
    chk_bit("cmp_pin2_out", 1'b0, cmp_pin2_out);
    rd(8'h19, 8'h01, "comparator_control");
  endtask
  task automatic t_refsel;
    bus(1'b1, 8'h99, 8'h80);
    @(posedge ref_clk);
    neg_set <= 7'h14;
    bus(1'b1, 8'h19, 8'h03);
    settle;
    chk_bit("cmp_pin2_out", 1'b1, cmp_pin2_out);
    @(posedge ref_clk);
    neg_set <= 7'h1E;
    settle;
    chk_bit("cmp_pin2_out", 1'b0, cmp_pin2_out);
    @(posedge ref_clk);
    pos_set <= 7'h14;
    neg_set <= 7'h3C;
    bus(1'b1, 8'h19, 8'h0D);
    settle;
    rd(8'h19, 8'h4D, "comparator_control");
    bus(1'b1, 8'h19, 8'h05);
    settle;
    rd(8'h19, 8'h05, "comparator_control");
  endtask
  task automatic t_flag;
    bus(1'b1, 8'h19, 8'h01);
    settle;
    rd(8'h19, 8'h01, "comparator_control");
    bus(1'b1, 8'h0C, 8'h00);
    rd(8'h0C, 8'h00, "change_flag");
    @(posedge ref_clk);
    pos_set <= 7'h50;
    settle;
    rd(8'h0C, 8'h08, "change_flag");
    chk_bit("compare_change_flag", 1'b1, compare_change_flag);
    bus(1'b1, 8'h0C, 8'h00);
    rd(8'h0C, 8'h08, "change_flag");
    rd(8'h19, 8'h41, "comparator_control");
    bus(1'b1, 8'h0C, 8'h00);
    rd(8'h0C, 8'h00, "change_flag");
    @(posedge ref_clk);
    sleep_mode <= 1'b1;
    pos_set <= 7'h0A;
    settle;
    chk_bit("wake_request", 1'b1, wake_request);
    rd(8'h19, 8'h01, "comparator_control");
    rd(8'h99, 8'h80, "reference_control");
    @(negedge ref_clk);
    chk_bit("wake_request", 1'b0, wake_request);
    @(posedge ref_clk);
    sleep_mode <= 1'b0;
  endtask
  task automatic t_pins;
    @(posedge ref_clk);
    dig_set <= 6'h3F;
    bus(1'b1, 8'h19, 8'h00);
    settle;
    rd(8'h05, 8'h38, "port_pins");
    bus(1'b1, 8'h19, 8'h07);
    settle;
    rd(8'h05, 8'h3F, "port_pins");
    bus(1'b1, 8'h40, 8'hFF);
    rd(8'h40, 8'h00, "unmapped");
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    end_of_test;
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    t_reset;
    t_ref;
    t_modes;
    t_cmp;
    t_refsel;
    t_flag;
    t_pins;
    end_of_test;
  end
endmodule
